// ==== pkg/owbr_pkg.sv ====
package owbr_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_NS             = 10;
    localparam int unsigned T_STREAM_END_NS    = 2000;
    localparam int unsigned STREAM_END_CYC     = (T_STREAM_END_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned T_ACK_VALID_NS     = 4000;
    localparam int unsigned ACK_VALID_CYC      = (T_ACK_VALID_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned T_ACK_PULSE_US     = 512;
    localparam int unsigned ACK_PULSE_CYC_DEF  = (T_ACK_PULSE_US * 1000) / CLK_NS;
    localparam int unsigned T_DISABLE_US       = 2500;
    localparam int unsigned DISABLE_CYC_DEF    = (T_DISABLE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned T_BIT_TIMEOUT_US   = 600;
    localparam int unsigned BIT_TIMEOUT_CYC_DEF = (T_BIT_TIMEOUT_US * 1000) / CLK_NS;

    // ------------------------------------------------------------------
    // Command word layout
    // ------------------------------------------------------------------
    localparam int unsigned CMD_BITS    = 24;
    localparam int unsigned BITCNT_W    = 5;
    localparam int unsigned ADDR_LSB    = 16;
    localparam int unsigned ADDR_W      = 8;
    localparam logic [7:0]  DEV_ADDR    = 8'h8F;
    localparam int unsigned ACKREQ_POS  = 10;
    localparam logic [23:0] RSV_MASK    = 24'h00FA00;
    localparam int unsigned BRIGHT_W    = 9;
    localparam logic [8:0]  BRIGHT_RST  = 9'h1FF;

    // ------------------------------------------------------------------
    // Counter widths
    // ------------------------------------------------------------------
    localparam int unsigned PHASE_W     = 16;
    localparam int unsigned RUN_W       = 18;
    localparam int unsigned ACKCNT_W    = 16;
    localparam int unsigned EVCNT_W     = 8;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [3:0]  REG_BRIGHT      = 4'h0;
    localparam logic [3:0]  REG_STATUS      = 4'h4;
    localparam logic [3:0]  REG_CTRL        = 4'h8;
    localparam int unsigned CTRL_ACKEN_POS  = 0;
    localparam logic        CTRL_ACKEN_RST  = 1'b1;
    localparam int unsigned STAT_EN_POS     = 0;
    localparam int unsigned STAT_BUSY_POS   = 1;
    localparam int unsigned STAT_GOOD_LSB   = 8;
    localparam int unsigned STAT_ERR_LSB    = 16;

    // ------------------------------------------------------------------
    // Receiver states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE       = 3'h0,
        ST_RECV       = 3'h1,
        ST_STREAM_END = 3'h3,
        ST_AWAIT      = 3'h2,
        ST_APULSE     = 3'h6
    } owbr_state_t;

    function automatic logic ge_twice(input logic [PHASE_W-1:0] a,
                                      input logic [PHASE_W-1:0] b);
        ge_twice = {1'b0, a} >= {b, 1'b0};
    endfunction : ge_twice

endpackage : owbr_pkg

// ==== src/owbr_bit_timer.sv ====
module owbr_bit_timer
    import owbr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic fall_i,
    input  wire logic rise_i,
    input  wire logic restart_i,
    output logic      bit_stb_o,
    output logic      bit_val_o,
    output logic      bit_bad_o
);

    logic [PHASE_W-1:0] cnt_q;
    logic [PHASE_W-1:0] cnt_d;
    logic [PHASE_W-1:0] low_q;
    logic [PHASE_W-1:0] low_d;
    logic               rose_q;
    logic               rose_d;
    logic               stb_q;
    logic               stb_d;
    logic               val_q;
    logic               val_d;
    logic               bad_q;
    logic               bad_d;

    // ------------------------------------------------------------------
    // Phase measurement, fall to fall
    // ------------------------------------------------------------------
    always_comb begin
        // Saturates so very slow bits still compare sanely
        cnt_d  = (fall_i || rise_i) ? '0 : ((&cnt_q) ? cnt_q : cnt_q + 1'b1);
        low_d  = low_q;
        rose_d = rose_q;
        stb_d  = 1'b0;
        val_d  = val_q;
        bad_d  = bad_q;
        if (rise_i) begin
            low_d  = cnt_q;
            rose_d = 1'b1;
        end
        if (fall_i) begin
            rose_d = 1'b0;
            if (rose_q && !restart_i) begin
                stb_d = 1'b1;
                val_d = ge_twice(cnt_q, low_q);
                bad_d = !ge_twice(cnt_q, low_q) && !ge_twice(low_q, cnt_q);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q  <= '0;
            low_q  <= '0;
            rose_q <= 1'b0;
            stb_q  <= 1'b0;
            val_q  <= 1'b0;
            bad_q  <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            low_q  <= low_d;
            rose_q <= rose_d;
            stb_q  <= stb_d;
            val_q  <= val_d;
            bad_q  <= bad_d;
        end
    end

    assign bit_stb_o = stb_q;
    assign bit_val_o = val_q;
    assign bit_bad_o = bad_q;

endmodule : owbr_bit_timer

// ==== src/owbr_receiver.sv ====
// Overview of operation
// - Commands are 24 bits, least significant bit first, shifted in from the top.
// - If the line is already high, the next falling edge starts bit one.
// - At least 2 us of low idle after the last bit closes a command.
// - Bit is 0 when low >= 2x high, 1 when high >= 2x low.
// - A bit runs from one falling edge to the next; both phases are timed.
// - Bit 10 requests an acknowledge, given by pulling the line low.
// - Bits 8 to 0 hold the 9-bit brightness code, bit 8 highest.
// - Acknowledge only if requested, address matches and all 24 bits were good.
// - After the valid delay from the last fall, pull low up to 512 us.
// - Address bits 23 to 16 must equal 0x8F.
// - Brightness code is all ones when enabled and after any disable.
// - Bits decode at any rate from 1.7 to 160 kbit/s unconfigured.
// - Line low longer than 2.5 ms disables the device, code to default.
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
module owbr_receiver
    import owbr_pkg::*;
#(
    parameter int unsigned DISABLE_CYC     = DISABLE_CYC_DEF,
    parameter int unsigned ACK_PULSE_CYC   = ACK_PULSE_CYC_DEF,
    parameter int unsigned BIT_TIMEOUT_CYC = BIT_TIMEOUT_CYC_DEF
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                en_i,
    output logic                     en_o,
    output logic                     en_oe_n_o,
    output logic [BRIGHT_W-1:0]      brightness_o,
    output logic                     enabled_o,
    input  wire logic [3:0]          avs_address_i,
    input  wire logic                avs_read_i,
    input  wire logic                avs_write_i,
    input  wire logic [31:0]         avs_writedata_i,
    input  wire logic [3:0]          avs_byteenable_i,
    output logic [31:0]              avs_readdata_o,
    output logic                     avs_waitrequest_o
);

    // ------------------------------------------------------------------
    // Pin synchroniser and edges
    // ------------------------------------------------------------------
    logic sync1_q;
    logic sync2_q;
    logic line_q;
    logic fall;
    logic rise;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            line_q  <= 1'b1;
        end else begin
            sync1_q <= en_i;
            sync2_q <= sync1_q;
            line_q  <= sync2_q;
        end
    end

    assign fall = line_q && !sync2_q;
    assign rise = !line_q && sync2_q;

    // ------------------------------------------------------------------
    // Receiver state
    // ------------------------------------------------------------------
    owbr_state_t           state_q;
    owbr_state_t           state_d;
    logic [CMD_BITS-1:0]   shift_q;
    logic [CMD_BITS-1:0]   shift_d;
    logic [BITCNT_W-1:0]   bitcnt_q;
    logic [BITCNT_W-1:0]   bitcnt_d;
    logic [RUN_W-1:0]      run_q;
    logic [RUN_W-1:0]      run_d;
    logic [ACKCNT_W-1:0]   ackcnt_q;
    logic [ACKCNT_W-1:0]   ackcnt_d;
    logic [BRIGHT_W-1:0]   bright_q;
    logic [BRIGHT_W-1:0]   bright_d;
    logic                  enabled_q;
    logic                  enabled_d;
    logic                  pull_q;
    logic                  pull_d;
    logic [EVCNT_W-1:0]    good_q;
    logic [EVCNT_W-1:0]    good_d;
    logic [EVCNT_W-1:0]    err_q;
    logic [EVCNT_W-1:0]    err_d;
    logic                  ack_en_q;
    logic                  restart;
    logic                  bit_stb;
    logic                  bit_val;
    logic                  bit_bad;
    logic                  cmd_ok;
    logic                  acking;

    assign restart = (state_q == ST_IDLE);
    assign acking  = (state_q == ST_AWAIT) || (state_q == ST_APULSE);
    assign cmd_ok  = (shift_q[ADDR_LSB +: ADDR_W] == DEV_ADDR)
                  && ((shift_q & RSV_MASK) == '0);

    owbr_bit_timer u_bit_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .fall_i    (fall),
        .rise_i    (rise),
        .restart_i (restart),
        .bit_stb_o (bit_stb),
        .bit_val_o (bit_val),
        .bit_bad_o (bit_bad)
    );

    always_comb begin
        state_d   = state_q;
        shift_d   = shift_q;
        bitcnt_d  = bitcnt_q;
        ackcnt_d  = ackcnt_q;
        bright_d  = bright_q;
        enabled_d = enabled_q;
        pull_d    = pull_q;
        good_d    = good_q;
        err_d     = err_q;
        // Time since last edge of the line
        run_d     = (fall || rise) ? '0 : ((&run_q) ? run_q : run_q + 1'b1);

        case (state_q)
            ST_IDLE: begin
                bitcnt_d = '0;
                if (fall && enabled_q) begin
                    state_d = ST_RECV;
                end
            end
            ST_RECV: begin
                if (bit_stb) begin
                    shift_d  = {bit_val, shift_q[CMD_BITS-1:1]};
                    bitcnt_d = bitcnt_q + 1'b1;
                    if (bit_bad) begin
                        state_d = ST_IDLE;
                        err_d   = err_q + 1'b1;
                    end else if (bitcnt_q == BITCNT_W'(CMD_BITS - 1)) begin
                        state_d = ST_STREAM_END;
                    end
                end else if (run_q >= RUN_W'(BIT_TIMEOUT_CYC)) begin
                    // Stalled stream: too few bits
                    state_d = ST_IDLE;
                    err_d   = err_q + 1'b1;
                end
            end
            ST_STREAM_END: begin
                if (sync2_q) begin
                    // A rise means a 25th bit, not an end of stream
                    state_d = ST_IDLE;
                    err_d   = err_q + 1'b1;
                end else if (run_q >= RUN_W'(STREAM_END_CYC)) begin
                    if (cmd_ok) begin
                        bright_d = shift_q[BRIGHT_W-1:0];
                        good_d   = good_q + 1'b1;
                        if (shift_q[ACKREQ_POS] && ack_en_q) begin
                            state_d = ST_AWAIT;
                        end else begin
                            state_d = ST_IDLE;
                        end
                    end else begin
                        state_d = ST_IDLE;
                        err_d   = err_q + 1'b1;
                    end
                end
            end
            ST_AWAIT: begin
                // Measured from the last falling edge
                if (run_q >= RUN_W'(ACK_VALID_CYC)) begin
                    state_d  = ST_APULSE;
                    pull_d   = 1'b1;
                    ackcnt_d = '0;
                end
            end
            ST_APULSE: begin
                ackcnt_d = ackcnt_q + 1'b1;
                if (ackcnt_q >= ACKCNT_W'(ACK_PULSE_CYC - 1)) begin
                    state_d = ST_IDLE;
                    pull_d  = 1'b0;
                end
            end
            default: begin
                state_d = ST_IDLE;
                pull_d  = 1'b0;
            end
        endcase

        // Own pull-down must not count as a master hold
        if (sync2_q) begin
            enabled_d = 1'b1;
        end else if (!acking && enabled_q && run_q >= RUN_W'(DISABLE_CYC)) begin
            enabled_d = 1'b0;
            bright_d  = BRIGHT_RST;
            state_d   = ST_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q   <= ST_IDLE;
            shift_q   <= '0;
            bitcnt_q  <= '0;
            run_q     <= '0;
            ackcnt_q  <= '0;
            bright_q  <= BRIGHT_RST;
            enabled_q <= 1'b0;
            pull_q    <= 1'b0;
            good_q    <= '0;
            err_q     <= '0;
        end else begin
            state_q   <= state_d;
            shift_q   <= shift_d;
            bitcnt_q  <= bitcnt_d;
            run_q     <= run_d;
            ackcnt_q  <= ackcnt_d;
            bright_q  <= bright_d;
            enabled_q <= enabled_d;
            pull_q    <= pull_d;
            good_q    <= good_d;
            err_q     <= err_d;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive: open drain, only ever pulls low
    // ------------------------------------------------------------------
    logic oe_n_q;
    logic drv_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oe_n_q <= 1'b1;
            drv_q  <= 1'b0;
        end else begin
            oe_n_q <= !pull_d;
            drv_q  <= 1'b0;
        end
    end

    assign en_o         = drv_q;
    assign en_oe_n_o    = oe_n_q;
    assign brightness_o = bright_q;
    assign enabled_o    = enabled_q;

    // ------------------------------------------------------------------
    // Avalon-MM slave, one wait cycle per access
    // ------------------------------------------------------------------
    logic        wait_q;
    logic        wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        ack_en_d;

    always_comb begin
        wait_d   = 1'b1;
        rdata_d  = rdata_q;
        ack_en_d = ack_en_q;
        if ((avs_read_i || avs_write_i) && wait_q) begin
            wait_d  = 1'b0;
            rdata_d = '0;
            if (avs_read_i) begin
                case (avs_address_i)
                    REG_BRIGHT: rdata_d[BRIGHT_W-1:0] = bright_q;
                    REG_STATUS: begin
                        rdata_d[STAT_EN_POS]                  = enabled_q;
                        rdata_d[STAT_BUSY_POS]                = (state_q != ST_IDLE);
                        rdata_d[STAT_GOOD_LSB +: EVCNT_W]     = good_q;
                        rdata_d[STAT_ERR_LSB +: EVCNT_W]      = err_q;
                    end
                    REG_CTRL:   rdata_d[CTRL_ACKEN_POS] = ack_en_q;
                    default:    rdata_d = '0;
                endcase
            end
        end
        // Write lands on the edge that sees waitrequest low
        if (avs_write_i && !wait_q && avs_address_i == REG_CTRL && avs_byteenable_i[0]) begin
            ack_en_d = avs_writedata_i[CTRL_ACKEN_POS];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_q   <= 1'b1;
            rdata_q  <= '0;
            ack_en_q <= CTRL_ACKEN_RST;
        end else begin
            wait_q   <= wait_d;
            rdata_q  <= rdata_d;
            ack_en_q <= ack_en_d;
        end
    end

    assign avs_readdata_o    = rdata_q;
    assign avs_waitrequest_o = wait_q;

endmodule : owbr_receiver

// ==== verif/owbr_assertions.sv ====
module owbr_checker
    import owbr_pkg::*;
#(
    parameter int unsigned DISABLE_CYC     = DISABLE_CYC_DEF,
    parameter int unsigned ACK_PULSE_CYC   = ACK_PULSE_CYC_DEF,
    parameter int unsigned BIT_TIMEOUT_CYC = BIT_TIMEOUT_CYC_DEF
) (
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic                en_i,
    input wire logic                en_o,
    input wire logic                en_oe_n_o,
    input wire logic [BRIGHT_W-1:0] brightness_o,
    input wire logic                enabled_o,
    input wire logic                avs_read_i,
    input wire logic                avs_write_i,
    input wire logic                avs_waitrequest_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Run counters of line low and pull-down
    // ----
    logic [17:0] low_run_q, low_run_d;
    logic [17:0] ack_run_q, ack_run_d;
    always_comb begin
        low_run_d = (en_i || (&low_run_q)) ? (en_i ? 18'h0 : low_run_q) : low_run_q + 18'h1;
        ack_run_d = en_oe_n_o ? 18'h0 : ack_run_q + 18'h1;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_run_q <= 18'h0;
            ack_run_q <= 18'h0;
        end else begin
            low_run_q <= low_run_d;
            ack_run_q <= ack_run_d;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_pin_zero: assert property (en_o == 1'b0)
        else $error("pin drive value not zero");
    chk_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("bus request not answered next cycle");
    chk_bus_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low longer than one cycle");
    chk_ack_length: assert property ($rose(en_oe_n_o) |-> ack_run_q == 18'(ACK_PULSE_CYC))
        else $error("acknowledge pulse length wrong");
    chk_ack_bound: assert property (ack_run_q <= 18'(ACK_PULSE_CYC))
        else $error("acknowledge pulse too long");
    chk_ack_delay: assert property ($fell(en_oe_n_o) |-> low_run_q >= 18'(ACK_VALID_CYC))
        else $error("acknowledge before valid delay");
    chk_ack_enabled: assert property (!en_oe_n_o |-> enabled_o)
        else $error("acknowledge while disabled");
    chk_store_end: assert property ($changed(brightness_o) && enabled_o && $past(enabled_o)
        |-> low_run_q >= 18'(STREAM_END_CYC)) else $error("code stored before stream end");
    chk_disable_time: assert property ($fell(enabled_o) |-> low_run_q >= 18'(DISABLE_CYC))
        else $error("disabled too early");
    chk_disable_code: assert property ($fell(enabled_o)
        |-> ##[0:2] brightness_o == BRIGHT_RST) else $error("code not default after disable");
    cov_ack: cover property ($fell(en_oe_n_o));
    cov_store: cover property ($changed(brightness_o) && enabled_o);
    cov_disable: cover property ($fell(enabled_o));
endmodule : owbr_checker

bind owbr_receiver owbr_checker #(
    .DISABLE_CYC(DISABLE_CYC),
    .ACK_PULSE_CYC(ACK_PULSE_CYC),
    .BIT_TIMEOUT_CYC(BIT_TIMEOUT_CYC)
) i_chk (.clk_i, .rst_i, .en_i, .en_o, .en_oe_n_o, .brightness_o, .enabled_o,
         .avs_read_i, .avs_write_i, .avs_waitrequest_o);

// ==== verif/owbr_host_model.sv ====
module owbr_host_model
    import owbr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic line_i,
    output logic      host_low_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Open-drain master; high level comes from the pull-up
    // ----
    initial host_low_o = 1'b0;
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_cyc
    task automatic hold_low(input int n);
        host_low_o <= 1'b1;
        wait_cyc(n);
    endtask : hold_low
    // Edge first, so a preceding fall is never overwritten in the same step
    task automatic idle(input int n);
        @(posedge clk_i);
        host_low_o <= 1'b0;
        wait_cyc(n);
    endtask : idle
    task automatic start();
        idle(250);
        host_low_o <= 1'b1;
    endtask : start
    task automatic drive_bit(input int tl, input int th);
        wait_cyc(tl);
        host_low_o <= 1'b0;
        wait_cyc(th);
        host_low_o <= 1'b1;
    endtask : drive_bit
    task automatic send_bits(input logic [23:0] w, input int n, input int u);
        for (int i = 0; i < n; i++) begin
            if (w[i]) drive_bit(u, 3 * u);
            else drive_bit(3 * u, u);
        end
    endtask : send_bits
    task automatic finish(output logic acked);
        int n;
        wait_cyc(410);
        host_low_o <= 1'b0;
        wait_cyc(8);
        acked = ~line_i;
        n = 0;
        while (line_i !== 1'b1 && n < 1000) begin
            wait_cyc(1);
            n++;
        end
    endtask : finish
    task automatic send_cmd(input logic [23:0] w, input int u, output logic acked);
        start();
        send_bits(w, 24, u);
        finish(acked);
    endtask : send_cmd
endmodule : owbr_host_model

// ==== verif/testbench.sv ====
module testbench
    import owbr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned DIS_CYC   = 3000;
    localparam int unsigned ACK_CYC   = 500;
    localparam int unsigned BTO_CYC   = 2000;
    localparam int          CYC_LIMIT = 60000;
    typedef struct {logic [23:0] w; int u; logic [8:0] b; logic ack;} owbr_row_t;
    logic                clk_i, rst_i, host_low, en_line, en_o, en_oe_n_o, enabled_o;
    logic [BRIGHT_W-1:0] brightness_o;
    logic [3:0]          avs_addr;
    logic [3:0]          avs_be = 4'hF;
    logic                avs_rd_en, avs_wr_en, avs_waitrequest_o, acked;
    logic [31:0]         avs_wdata, avs_readdata_o, rd;
    int                  bad_count, cmp_count;
    int                  cyc_count = 0;
    owbr_row_t           rows [7];
    // ----
    // Wire with pull-up, device and master both open-drain
    // ----
    assign en_line = host_low ? 1'b0 : (en_oe_n_o ? 1'b1 : en_o);
    owbr_receiver #(
        .DISABLE_CYC(DIS_CYC),
        .ACK_PULSE_CYC(ACK_CYC),
        .BIT_TIMEOUT_CYC(BTO_CYC)
    ) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .en_i(en_line), .en_o(en_o), .en_oe_n_o(en_oe_n_o),
        .brightness_o(brightness_o), .enabled_o(enabled_o), .avs_address_i(avs_addr),
        .avs_read_i(avs_rd_en), .avs_write_i(avs_wr_en), .avs_writedata_i(avs_wdata),
        .avs_byteenable_i(avs_be), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o)
    );
    owbr_host_model i_host (.clk_i(clk_i), .line_i(en_line), .host_low_o(host_low));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic end_sim();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask : chk
    task automatic avs(input logic we, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] d);
        int n;
        @(posedge clk_i);
        avs_addr <= a;
        avs_wdata <= wd;
        avs_wr_en <= we;
        avs_rd_en <= ~we;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0);
        d = avs_readdata_o;
        avs_wr_en <= 1'b0;
        avs_rd_en <= 1'b0;
        chk("avs_answer", 32'h2, 32'(n));
    endtask : avs
    task automatic wait_en();
        int n;
        n = 0;
        while (enabled_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        chk("enabled", 32'h1, 32'(enabled_o));
    endtask : wait_en
    always @(posedge clk_i) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == CYC_LIMIT) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        rst_i = 1'b1;
        avs_addr = 4'h0;
        avs_rd_en = 1'b0;
        avs_wr_en = 1'b0;
        avs_wdata = 32'h0;
        bad_count = 0;
        cmp_count = 0;
        rows = '{'{24'h8F04A5, 10, 9'h0A5, 1'b1}, '{24'h8F015A, 157, 9'h15A, 1'b0},
                 '{24'h8E0433, 10, 9'h15A, 1'b0}, '{24'h8F0644, 10, 9'h15A, 1'b0},
                 '{24'h8F8444, 4, 9'h15A, 1'b0}, '{24'h8F0400, 4, 9'h000, 1'b1},
                 '{24'h8F05FF, 25, 9'h1FF, 1'b1}};
        repeat (16) @(posedge clk_i);
        chk("oe_rst", 32'h1, 32'(en_oe_n_o));
        chk("bright_rst", 32'h1FF, 32'(brightness_o));
        chk("en_rst", 32'h0, 32'(enabled_o));
        chk("wait_rst", 32'h1, 32'(avs_waitrequest_o));
        rst_i <= 1'b0;
        wait_en();
        avs(1'b0, REG_CTRL, 32'h0, rd);
        chk("ctrl_rst", 32'h1, rd);
        avs(1'b1, 4'hC, 32'hFFFFFFFF, rd);
        avs(1'b0, 4'hC, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        avs(1'b1, REG_BRIGHT, 32'h0, rd);
        avs(1'b0, REG_BRIGHT, 32'h0, rd);
        chk("bright_ro", 32'h1FF, rd);
        // ----
        // Command table, mixed rates
        // ----
        for (int r = 0; r < 7; r++) begin
            i_host.send_cmd(rows[r].w, rows[r].u, acked);
            chk("brightness", 32'(rows[r].b), 32'(brightness_o));
            chk("ack", 32'(rows[r].ack), 32'(acked));
            avs(1'b0, REG_BRIGHT, 32'h0, rd);
            chk("bright_reg", 32'(rows[r].b), rd);
        end
        // ----
        // Awkward cases
        // ----
        avs(1'b1, REG_CTRL, 32'h0, rd);
        i_host.send_cmd(24'h8F0411, 10, acked);
        chk("bright_noack", 32'h011, 32'(brightness_o));
        chk("ack_off", 32'h0, 32'(acked));
        avs(1'b1, REG_CTRL, 32'h1, rd);
        // Ten bits then high: a short command must not land
        i_host.start();
        i_host.send_bits(24'h8F05AA, 10, 10);
        i_host.idle(2500);
        chk("bright_short", 32'h011, 32'(brightness_o));
        avs(1'b0, REG_STATUS, 32'h0, rd);
        chk("status", 32'h00040501, rd);
        // Ratio 1.5 in bit 5 must spoil the whole command
        i_host.start();
        i_host.send_bits(24'h8F05AA, 5, 10);
        i_host.drive_bit(15, 10);
        i_host.send_bits(24'h8F05AA >> 6, 18, 10);
        i_host.finish(acked);
        chk("bright_ratio", 32'h011, 32'(brightness_o));
        chk("ack_ratio", 32'h0, 32'(acked));
        i_host.hold_low(DIS_CYC + 100);
        chk("disabled", 32'h0, 32'(enabled_o));
        chk("bright_dis", 32'h1FF, 32'(brightness_o));
        i_host.idle(30);
        wait_en();
        chk("bright_reen", 32'h1FF, 32'(brightness_o));
        // Reset in mid-run brings the code back to its default
        i_host.send_cmd(24'h8F0033, 10, acked);
        chk("bright_pre_rst", 32'h033, 32'(brightness_o));
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("bright_mid_rst", 32'h1FF, 32'(brightness_o));
        chk("en_mid_rst", 32'h0, 32'(enabled_o));
        rst_i <= 1'b0;
        wait_en();
        end_sim();
    end
endmodule : testbench
